// >>> hdl/touch_cmd_pkg.sv
package touch_cmd_pkg;
  localparam int        NUM_KEYS    = 48;
  localparam logic [7:0] CMD_REFS   = 8'h09;
  localparam logic [7:0] CMD_DELTAS = 8'h0A;
  localparam logic [7:0] CMD_ERRS   = 8'h0B;
  localparam logic [7:0] CMD_FAULT  = 8'h0C;
  localparam logic [7:0] CMD_SETUPS = 8'h0D;
  localparam logic [7:0] CMD_NVCRC  = 8'h0E;
  localparam logic [7:0] CMD_LAST   = 8'h0F;
  localparam logic [7:0] CMD_DIAG1  = 8'h10;
  localparam logic [7:0] CMD_DIAG3  = 8'h11;
  localparam logic [7:0] CMD_DIAG2  = 8'h12;
  localparam logic [7:0] CMD_SLEEP  = 8'h16;
  localparam logic [1:0] GRP_DATA   = 2'h1;
  localparam logic [1:0] GRP_STAT   = 2'h2;
  localparam logic [1:0] GRP_CAL    = 2'h3;
  localparam logic [7:0] RESTART    = 8'h01;
  localparam logic [7:0] CRC8_POLY  = 8'h07;
  localparam int        SETUPS_LEN  = 247;
  localparam int        STAT_EN     = 4;
  localparam int        STAT_DET    = 3;
  localparam int        STAT_LOW    = 2;
  localparam int        STAT_CAL    = 1;
  localparam int        STAT_FAIL   = 0;
  localparam int        ERR_BIT     = 6;
  localparam int        CLK_HZ      = 10_000_000;
  localparam int        TIMEOUT_MS  = 100;
  localparam int        TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int        DIAG_CODE   = 24'h5A3C96; // arbitrary value
  localparam int        NUM_RAM     = 256;
endpackage

// >>> hdl/setups_ram.sv
`timescale 1ns/1ps
module setups_ram (
  input  wire logic       clk,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic [7:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// >>> hdl/touch_cmd.sv
`timescale 1ns/1ps
module touch_cmd #(
  parameter int TIMEOUT = touch_cmd_pkg::TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        txReady,
  output logic             txValid,
  output logic [7:0]       txData,
  output logic             hostPacingLine,
  output logic             scanHalt,
  output logic             sleepMode,
  input  wire logic        wakePin,
  output logic             calStart,
  output logic [5:0]       calKey,
  output logic             commsError,
  output logic [5:0]       keySel,
  input  wire logic [15:0] keySignal,
  input  wire logic [15:0] keyReference,
  input  wire logic [7:0]  normalIntegratorCount,
  input  wire logic [4:0]  keyStatus,
  input  wire logic        keyError,
  input  wire logic [7:0]  faultBits,
  input  wire logic        setupWrEn,
  input  wire logic [7:0]  setupWrAddr,
  input  wire logic [7:0]  setupWrData,
  input  wire logic [15:0] setupCrc
);
  import touch_cmd_pkg::*;

  typedef enum {S_IDLE, S_LOAD, S_SEND, S_WAIT, S_SLEEP, S_WAKE} state_e;
  state_e state;

  // ----------------------------------------------------------
  // input sync for the wake pin
  // ----------------------------------------------------------
  logic wakeMeta;
  logic wakeSync;
  always_ff @(posedge clk) begin
    wakeMeta <= wakePin;
    wakeSync <= wakeMeta;
  end

  // ----------------------------------------------------------
  // response bookkeeping
  // ----------------------------------------------------------
  logic [7:0]  cmd;
  logic [7:0]  prevCmd;
  logic [8:0]  idx;
  logic [8:0]  total;
  logic        withCrc;
  logic [7:0]  crc8;
  logic [7:0]  pendCmd;
  logic        pending;
  logic [23:0] gap;
  logic        isDump;
  logic [7:0]  ramData;
  logic [7:0]  ramAddr;
  logic [7:0]  nextByte;
  logic [7:0] ramIdx;
  // error flags pack eight keys per byte; keys walked in bit order
  logic [7:0]  errByte;
  logic [2:0]  errBit;

  function automatic logic [7:0] crc8Step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign ramIdx  = idx[7:0];
  assign ramAddr = ramIdx;

  setups_ram ram (
    .clk    (clk),
    .wrEn   (setupWrEn),
    .wrAddr (setupWrAddr),
    .wrData (setupWrData),
    .rdAddr (ramAddr),
    .rdData (ramData)
  );

  logic [5:0] keyIdx;
  logic       keyOk;
  assign keyIdx = rxData[5:0];
  assign keyOk  = keyIdx < 6'(NUM_KEYS);

  logic known;
  always_comb begin
    known = 1'b1;
    case (rxData)
      CMD_REFS, CMD_DELTAS, CMD_ERRS, CMD_FAULT, CMD_SETUPS,
      CMD_NVCRC, CMD_LAST, CMD_DIAG1, CMD_DIAG3, CMD_DIAG2,
      CMD_SLEEP: known = 1'b1;
      default: known = (rxData[7:6] != 2'h0) && keyOk;
    endcase
  end

  // byte selected for the current index of the current command
  always_comb begin
    nextByte = 8'h00;
    case (cmd)
      CMD_REFS: begin
        nextByte = idx[0] ? keyReference[15:8] : keyReference[7:0];
      end
      CMD_DELTAS: begin
        nextByte = 8'(keyReference - keySignal);
      end
      CMD_ERRS: nextByte = {keyError, errByte[7:1]};
      CMD_FAULT: nextByte = faultBits;
      CMD_SETUPS: begin
        if (idx < 9'(SETUPS_LEN)) begin
          nextByte = ramData;
        end else begin
          nextByte = idx[0] ? setupCrc[7:0] : setupCrc[15:8];
        end
      end
      CMD_NVCRC: nextByte = idx[0] ? setupCrc[15:8] : setupCrc[7:0];
      CMD_LAST: nextByte = ~prevCmd;
      CMD_DIAG1, CMD_DIAG3, CMD_DIAG2: begin
        nextByte = 8'(DIAG_CODE >> (idx * 8));
      end
      default: begin
        case (cmd[7:6])
          GRP_DATA: begin
            case (idx)
              9'd0: nextByte = keySignal[7:0];
              9'd1: nextByte = keySignal[15:8];
              9'd2: nextByte = keyReference[7:0];
              9'd3: nextByte = keyReference[15:8];
              default: nextByte = normalIntegratorCount;
            endcase
          end
          GRP_STAT: nextByte = {3'h0, keyStatus};
          default: nextByte = ~cmd;
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      prevCmd <= 8'h00;
      idx <= 9'h000;
      total <= 9'h000;
      withCrc <= 1'b0;
      crc8 <= 8'h00;
      pending <= 1'b0;
      pendCmd <= 8'h00;
      gap <= 24'h000000;
      isDump <= 1'b0;
      txValid <= 1'b0;
      txData <= 8'h00;
      hostPacingLine <= 1'b1;
      scanHalt <= 1'b0;
      sleepMode <= 1'b0;
      calStart <= 1'b0;
      calKey <= 6'h00;
      commsError <= 1'b0;
      keySel <= 6'h00;
      errByte <= 8'h00;
      errBit <= 3'h0;
    end else begin
      calStart <= 1'b0;
      if (pending && state == S_IDLE) begin
        if (gap == 24'(TIMEOUT - 1)) begin
          pending <= 1'b0;
        end
        gap <= gap + 24'h000001;
      end
      case (state)
        S_IDLE: begin
          if (rxValid) begin
            prevCmd <= cmd;
            cmd <= rxData;
            idx <= 9'h000;
            crc8 <= crc8Step(8'h00, rxData);
            keySel <= 6'h00;
            errByte <= 8'h00;
            errBit <= 3'h0;
            isDump <= 1'b0;
            withCrc <= 1'b0;
            if (!known) begin
              commsError <= 1'b1;
              pending <= 1'b0;
            end else if (rxData == CMD_SLEEP
                         || rxData[7:6] == GRP_CAL) begin
              if (pending && pendCmd == rxData) begin
                pending <= 1'b0;
                total <= 9'd1;
                state <= S_LOAD;
                if (rxData[7:6] == GRP_CAL) begin
                  calStart <= 1'b1;
                  calKey <= keyIdx;
                end
              end else begin
                pending <= 1'b1;
                pendCmd <= rxData;
                gap <= 24'h000000;
              end
            end else begin
              pending <= 1'b0;
              state <= S_LOAD;
              case (rxData)
                CMD_REFS: total <= 9'd96;
                CMD_DELTAS: total <= 9'd48;
                CMD_ERRS: begin
                  total <= 9'd6;
                  withCrc <= 1'b1;
                end
                CMD_FAULT, CMD_DIAG1: begin
                  total <= 9'd1;
                  withCrc <= 1'b1;
                end
                CMD_SETUPS: begin
                  total <= 9'(SETUPS_LEN + 2);
                  isDump <= 1'b1;
                  scanHalt <= 1'b1;
                  state <= S_WAIT; // first ram read
                end
                CMD_NVCRC, CMD_DIAG2: total <= 9'd2;
                CMD_LAST: begin
                  total <= 9'd1;
                  commsError <= 1'b0;
                end
                CMD_DIAG3: begin
                  total <= 9'd3;
                  withCrc <= 1'b1;
                end
                default: begin
                  keySel <= keyIdx;
                  if (rxData[7:6] == GRP_DATA) begin
                    total <= 9'd5;
                  end else begin
                    total <= 9'd1;
                    withCrc <= 1'b1;
                  end
                end
              endcase
            end
          end
        end
        S_LOAD: begin
          if (idx == total) begin
            txData <= crc8;
            txValid <= 1'b1;
            withCrc <= 1'b0;
            gap <= 24'h000000;
            state <= S_SEND;
          end else if (cmd == CMD_ERRS && errBit != 3'h7) begin
            errByte <= nextByte;
            errBit <= errBit + 3'h1;
            keySel <= keySel + 6'h01;
          end else begin
            txData <= nextByte;
            txValid <= 1'b1;
            crc8 <= crc8Step(crc8, nextByte);
            gap <= 24'h000000;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          gap <= gap + 24'h000001;
          if (txReady) begin
            txValid <= 1'b0;
            if (idx == total) begin
              state <= S_IDLE;
              scanHalt <= 1'b0;
            end else begin
              idx <= idx + 9'h001;
              if (cmd == CMD_REFS && idx[0]) begin
                keySel <= keySel + 6'h01;
              end else if (cmd == CMD_DELTAS || cmd == CMD_ERRS) begin
                keySel <= keySel + 6'h01;
              end
              errBit <= 3'h0;
              if (idx + 9'h001 == total && !withCrc) begin
                if (cmd == CMD_SLEEP) begin
                  state <= S_SLEEP;
                  sleepMode <= 1'b1;
                  hostPacingLine <= 1'b0;
                end else begin
                  state <= S_IDLE;
                  scanHalt <= 1'b0;
                end
              end else begin
                state <= isDump ? S_WAIT : S_LOAD;
              end
            end
          end else if (isDump && gap == 24'(TIMEOUT - 1)) begin
            txValid <= 1'b0;
            scanHalt <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_WAIT: state <= S_LOAD; // ram read latency
        S_SLEEP: begin
          if (wakeSync) begin
            sleepMode <= 1'b0;
            hostPacingLine <= 1'b1;
            txData <= RESTART;
            txValid <= 1'b1;
            state <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (txReady) begin
            txValid <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  sequence sleepPair;
    state == S_IDLE && rxValid && rxData == CMD_SLEEP && pending
      && pendCmd == CMD_SLEEP;
  endsequence

  unknown_err_a: assert property (@(posedge clk) disable iff (rst)
    state == S_IDLE && rxValid && !known |=> commsError)
    else $error("unknown command did not flag error");
  last_clear_a: assert property (@(posedge clk) disable iff (rst)
    state == S_IDLE && rxValid && rxData == CMD_LAST |=> !commsError)
    else $error("last query did not clear error");
  sleep_low_a: assert property (@(posedge clk) disable iff (rst)
    sleepMode |-> !hostPacingLine)
    else $error("pacing line high while asleep");
  sleep_pair_a: assert property (@(posedge clk) disable iff (rst)
    sleepPair |=> ##[1:2] (txValid && txData == ~CMD_SLEEP))
    else $error("sleep pair not acknowledged");
  cal_key_a: assert property (@(posedge clk) disable iff (rst)
    calStart |-> calKey < 6'(NUM_KEYS))
    else $error("calibration key out of range");
  cal_ack_a: assert property (@(posedge clk) disable iff (rst)
    calStart |=> txValid && txData == ~cmd)
    else $error("calibration not acknowledged");
  dump_halt_a: assert property (@(posedge clk) disable iff (rst)
    isDump && state == S_SEND |-> scanHalt)
    else $error("scan not halted during dump");
  status_rsv_a: assert property (@(posedge clk) disable iff (rst)
    state == S_LOAD && cmd[7:6] == GRP_STAT && idx == 9'h000
      |=> txData[7:5] == 3'h0)
    else $error("reserved status bits set");
  wake_restart_a: assert property (@(posedge clk) disable iff (rst)
    state == S_SLEEP && wakeSync |=> txValid && txData == RESTART)
    else $error("no restart byte after wake");
endmodule

// >>> testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            txReady
);
  logic [1:0] cnt;
  initial begin
    txReady = 1'b0;
    cnt = 2'h0;
  end
  // 0 prompt, 1 slow (every fourth cycle), 2 stalled
  always @(negedge clk) begin
    cnt <= cnt + 2'h1;
    txReady <= (mode == 2'h0) || (mode == 2'h1 && cnt == 2'h0);
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  errorCnt++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end
module tb;
  import touch_cmd_pkg::*;
  localparam int TO = 50;
  logic        clk, rst, rxValid, txReady, txValid, hostPacingLine;
  logic        scanHalt, sleepMode, wakePin, calStart, commsError;
  logic        keyError, setupWrEn;
  logic [7:0]  rxData, txData, normalIntegratorCount, faultBits;
  logic [7:0]  setupWrAddr, setupWrData, crc;
  logic [5:0]  calKey, keySel;
  logic [15:0] keySignal, keyReference, setupCrc, r;
  logic [4:0]  keyStatus;
  logic [1:0]  mode;
  logic [7:0]  bad [4] = '{8'h13, 8'h70, 8'hB0, 8'hF0};
  int          errorCnt = 0, comparisons = 0, calCount = 0, k;
  // ------------------------------------------------------------------
  // key array and host
  // ------------------------------------------------------------------
  assign keySignal = 16'h1200 + {10'h000, keySel};
  assign keyReference = 16'h1200 + {8'h00, keySel, 2'h0};
  assign normalIntegratorCount = {2'h0, keySel};
  assign keyStatus = keySel[4:0];
  assign keyError = keySel[0] ^ keySel[3];
  host_model host (.clk(clk), .mode(mode), .txReady(txReady));
  touch_cmd #(.TIMEOUT(TO)) DUT (
    .clk(clk), .rst(rst), .rxValid(rxValid), .rxData(rxData),
    .txReady(txReady), .txValid(txValid), .txData(txData),
    .hostPacingLine(hostPacingLine), .scanHalt(scanHalt),
    .sleepMode(sleepMode), .wakePin(wakePin), .calStart(calStart),
    .calKey(calKey), .commsError(commsError), .keySel(keySel),
    .keySignal(keySignal), .keyReference(keyReference),
    .normalIntegratorCount(normalIntegratorCount),
    .keyStatus(keyStatus), .keyError(keyError), .faultBits(faultBits),
    .setupWrEn(setupWrEn), .setupWrAddr(setupWrAddr),
    .setupWrData(setupWrData), .setupCrc(setupCrc)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (calStart === 1'b1) calCount <= calCount + 1;
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction
  task automatic endOfTest();
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    @(negedge clk);
    rxValid = 1'b1;
    rxData = c;
    crc = crc8(8'h00, c);
    @(negedge clk);
    rxValid = 1'b0;
  endtask
  task automatic recv(output logic [7:0] b);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (txValid === 1'b1 && txReady === 1'b1) break;
    end
    if (i == 400) begin
      errorCnt++;
      endOfTest();
    end
    b = txData;
  endtask
  task automatic expb(input logic [7:0] e);
    logic [7:0] b;
    recv(b);
    `CHK(b, e)
    crc = crc8(crc, e);
  endtask
  task automatic quiet(input int n);
    repeat (n) @(negedge clk);
    `CHK(txValid, 1'b0)
  endtask
  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  initial begin
    {rxValid, rxData, wakePin, setupWrEn, setupWrAddr, setupWrData} = '0;
    faultBits = 8'h5A;
    setupCrc = 16'hB4C7;
    mode = 2'h1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK(hostPacingLine, 1'b1)
    for (k = 0; k < SETUPS_LEN; k++) begin
      setupWrEn = 1'b1;
      setupWrAddr = 8'(k);
      setupWrData = 8'(k) ^ 8'hC3;
      @(negedge clk);
    end
    setupWrEn = 1'b0;
    for (k = 0; k < 4; k++) begin
      cmd(bad[k]);
      quiet(5);
      `CHK(commsError, 1'b1)
    end
    cmd(CMD_LAST);
    expb(~bad[3]);
    repeat (2) @(negedge clk);
    `CHK(commsError, 1'b0)
    cmd(CMD_REFS);
    for (k = 0; k < NUM_KEYS; k++) begin
      r = 16'h1200 + 16'(4 * k);
      expb(r[7:0]);
      expb(r[15:8]);
    end
    quiet(5);
    cmd(CMD_DELTAS);
    for (k = 0; k < NUM_KEYS; k++) expb(8'(3 * k));
    quiet(5);
    cmd(CMD_ERRS);
    for (k = 0; k < 6; k++) expb(k[0] ? 8'h55 : 8'hAA);
    expb(crc);
    cmd(CMD_FAULT);
    expb(8'h5A);
    expb(crc);
    cmd(CMD_NVCRC);
    expb(8'hC7);
    expb(8'hB4);
    cmd(CMD_DIAG3);
    expb(8'h96);
    expb(8'h3C);
    expb(8'h5A);
    expb(crc);
    cmd(CMD_DIAG2);
    expb(8'h96);
    expb(8'h3C);
    quiet(5);
    cmd(CMD_DIAG1);
    expb(8'h96);
    expb(crc);
    cmd(8'h6F);
    expb(8'h2F);
    expb(8'h12);
    expb(8'hBC);
    expb(8'h12);
    expb(8'h2F);
    quiet(5);
    cmd(8'h9F);
    expb(8'h1F);
    expb(crc);
    mode = 2'h0;
    cmd(CMD_SETUPS);
    `CHK(scanHalt, 1'b1)
    for (k = 0; k < SETUPS_LEN; k++) expb(8'(k) ^ 8'hC3);
    expb(8'hC7);
    expb(8'hB4);
    quiet(5);
    `CHK(scanHalt, 1'b0)
    mode = 2'h2;
    cmd(CMD_SETUPS);
    quiet(TO + 20);
    `CHK(scanHalt, 1'b0)
    mode = 2'h0;
    cmd(CMD_LAST);
    expb(8'hF2);
    cmd(8'hC3);
    cmd(8'hC3);
    expb(8'h3C);
    repeat (2) @(negedge clk);
    `CHK(calCount, 1)
    `CHK(calKey, 6'h03)
    cmd(8'hC5);
    quiet(TO + 10);
    cmd(8'hC5);
    quiet(TO + 10);
    `CHK(calCount, 1)
    cmd(CMD_SLEEP);
    quiet(TO + 10);
    `CHK(sleepMode, 1'b0)
    cmd(CMD_SLEEP);
    cmd(CMD_SLEEP);
    expb(8'hE9);
    repeat (3) @(negedge clk);
    `CHK(sleepMode, 1'b1)
    `CHK(hostPacingLine, 1'b0)
    wakePin = 1'b1;
    expb(RESTART);
    `CHK(hostPacingLine, 1'b1)
    `CHK(sleepMode, 1'b0)
    @(negedge clk);
    wakePin = 1'b0;
    endOfTest();
  end
endmodule
